/* core/bsc_pkg.sv */
package bsc_pkg;

   // ==========================================================
   // Chain geometry
   localparam int CHAIN_LEN = 205;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] LAST_BIT = 8'hcc;
   localparam int WORDS = 7;

   // ==========================================================
   // Cell positions
   localparam int POS_COMP = 200;
   localparam int POS_HSM = 196;
   localparam int POS_CONVERTER_ENABLE_CELL = 194;
   localparam int POS_DAC_LO = 183;
   localparam int DAC_W = 10;
   localparam int POS_HOLD = 178;
   localparam int POS_MUX_LO = 169;
   localparam int MUX_W = 8;
   localparam int POS_PASSEN = 165;
   localparam int POS_COMPARATOR_PRECHARGE_N = 164;
   localparam int POS_PEN = 160;
   localparam int PORT_CELLS = 160;
   localparam int PORTA_DATA0 = 14;
   localparam int CELLS_PER_PIN = 3;
   localparam int OFS_DRIVE = 1;
   localparam int OFS_PULLUP = 2;
   localparam int ANALOG_PIN = 3;

   // ==========================================================
   // Converter values
   localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
   localparam logic [MUX_W-1:0] MUX_IDLE = 8'h01;
   localparam int DUMMY_COMPARES = 10;
   localparam int COMPARE_CYC = 4;
   localparam int DUMMY_CYC = DUMMY_COMPARES * COMPARE_CYC;
   localparam int DUMMY_W = 6;

   // ==========================================================
   // Timing
   localparam int CLK_NS = 5;
   localparam int SETTLE_NS = 200;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_W = 6;
   localparam int TCK_HALF = 8;
   localparam int DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TCK_HALF - 1);

   // ==========================================================
   // Tester registers
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TX0 = 8'h10;
   localparam logic [7:0] REG_RX0 = 8'h30;
   localparam int CTRL_START = 0;
   localparam int CTRL_EXTEST = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_REFUSED = 1;
   localparam int STAT_SETTLING = 2;

   // Position of a port A cell; port A runs in ascending pin order.
   function automatic int porta_pos(input int pin, input int ofs);
      return PORTA_DATA0 + CELLS_PER_PIN * pin - ofs;
   endfunction

   // Idle chain: converter cells at their quiet values.
   function automatic logic [CHAIN_LEN-1:0] chain_idle();
      logic [CHAIN_LEN-1:0] v;
      v = '0;
      v[POS_HOLD] = 1'b1;
      v[POS_COMPARATOR_PRECHARGE_N] = 1'b1;
      v[POS_PASSEN] = 1'b1;
      v[POS_MUX_LO +: MUX_W] = MUX_IDLE;
      return v;
   endfunction

   typedef enum logic [3:0] {
      BSC_IDLE = 4'b0001,
      BSC_CAPTURE = 4'b0010,
      BSC_SHIFT = 4'b0100,
      BSC_UPDATE = 4'b1000
   } bsc_state_t;

endpackage

/* core/bsc_link_if.sv */
`timescale 1ns/1ps
interface bsc_link_if;
   logic tck;
   logic tdi;
   logic tdo;
   logic capture;
   logic shift;
   logic update;
   logic extest;

   modport device (input tck, input tdi, input capture, input shift, input update,
      input extest, output tdo);
   modport tester (output tck, output tdi, output capture, output shift, output update,
      output extest, input tdo);
endinterface

/* core/bsc_device.sv */
`timescale 1ns/1ps
module bsc_device
   import bsc_pkg::*;
(
   // System
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Link
   bsc_link_if.device link,
   // Analog side
   input wire logic comp_in,
   input wire logic prog_enable_in,
   output logic [bsc_pkg::DAC_W-1:0] dac_code,
   output logic [bsc_pkg::MUX_W-1:0] input_channel_mask,
   output logic sample_hold,
   output logic comparator_precharge_n,
   output logic converter_enable,
   output logic converter_busy,
   // Port pins
   output logic [bsc_pkg::PORT_CELLS-1:0] pin_cells
);
   import bsc_pkg::*;

   // ==========================================================
   // Synchronisers
   logic [1:0] tck_s, tdi_s, cap_s, sh_s, upd_s, ext_s, comp_s, pen_s;
   logic tck_d;
   always_ff @(posedge clk_sys)
   begin
      tck_s <= {tck_s[0], link.tck};
      tdi_s <= {tdi_s[0], link.tdi};
      cap_s <= {cap_s[0], link.capture};
      sh_s <= {sh_s[0], link.shift};
      upd_s <= {upd_s[0], link.update};
      ext_s <= {ext_s[0], link.extest};
      comp_s <= {comp_s[0], comp_in};
      pen_s <= {pen_s[0], prog_enable_in};
      tck_d <= tck_s[1];
   end
   wire tck_rise = tck_s[1] & ~tck_d;

   // ==========================================================
   // Chain
   logic [CHAIN_LEN-1:0] sr, upd, cap;
   logic comp_latch;
   always_comb
   begin
      cap = upd;
      cap[POS_COMP] = comp_latch;
      cap[POS_PEN] = pen_s[1];
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         sr <= '0;
         upd <= chain_idle();
      end
      else if (tck_rise)
      begin
         if (cap_s[1])
            sr <= cap;
         else if (sh_s[1])
            sr <= {tdi_s[1], sr[CHAIN_LEN-1:1]};
         if (upd_s[1])
            upd <= sr;
      end
   end
   assign link.tdo = sr[0];

   // ==========================================================
   // Applied cells; preload leaves the idle values in force
   wire [CHAIN_LEN-1:0] applied = ext_s[1] ? upd : chain_idle();
   assign dac_code = applied[POS_DAC_LO +: DAC_W];
   assign input_channel_mask = applied[POS_MUX_LO +: MUX_W];
   assign sample_hold = applied[POS_HOLD];
   assign comparator_precharge_n = applied[POS_COMPARATOR_PRECHARGE_N];
   assign converter_enable = applied[POS_CONVERTER_ENABLE_CELL];
   // Port cells sit below the analog cells, three per pin; the TAP pins own none.
   assign pin_cells = applied[PORT_CELLS-1:0];
   // The high-speed select cell and the PROGRAMMING_ENABLE_OBSERVE cell drive nothing.

   // ==========================================================
   // Comparator latch and dummy conversion
   logic en_d;
   logic [DUMMY_W-1:0] dummy_cnt;
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         comp_latch <= 1'b0;
      else if (!comparator_precharge_n)
         comp_latch <= comp_s[1];
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         en_d <= 1'b0;
         dummy_cnt <= '0;
      end
      else
      begin
         en_d <= converter_enable;
         if (converter_enable & ~en_d)
            dummy_cnt <= DUMMY_W'(DUMMY_CYC);
         else if (dummy_cnt != '0)
            dummy_cnt <= dummy_cnt - 1'b1;
      end
   end
   assign converter_busy = dummy_cnt != '0;

endmodule

/* core/bsc_tester.sv */
`timescale 1ns/1ps
module bsc_tester
   import bsc_pkg::*;
(
   // System
   input wire logic clk_sys,
   input wire logic sys_rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link
   bsc_link_if.tester link
);
   import bsc_pkg::*;

   // ==========================================================
   // Register decode
   logic [31:0] tx_word [WORDS];
   logic [31:0] rx_word [WORDS];
   logic extest_mode, refused;
   bsc_state_t state;
   logic [SETTLE_W-1:0] settle_cnt;
   // True for an aligned word inside a block of WORDS registers that starts at base.
   function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] ofs;
      ofs = a - base;
      return a >= base && ofs < 8'(4 * WORDS) && a[1:0] == 2'b00;
   endfunction

   wire wr = psel & penable & pwrite;
   wire [7:0] tx_ofs = paddr - REG_TX0;
   wire [7:0] rx_ofs = paddr - REG_RX0;
   wire [2:0] tx_idx = tx_ofs[4:2];
   wire [2:0] rx_idx = rx_ofs[4:2];
   wire is_ctrl = paddr == REG_CTRL;
   wire is_stat = paddr == REG_STATUS;
   wire is_tx = in_block(paddr, REG_TX0);
   wire is_rx = in_block(paddr, REG_RX0);
   wire mapped = is_ctrl | is_stat | is_tx | is_rx;
   wire busy = state != BSC_IDLE || settle_cnt != '0;
   wire [31:0] stat_val = {29'h0, settle_cnt != '0, refused, busy};
   wire [31:0] ctrl_val = {30'h0, extest_mode, 1'b0};
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = is_ctrl ? ctrl_val
                 : is_stat ? stat_val
                 : is_tx ? tx_word[tx_idx]
                 : is_rx ? rx_word[rx_idx]
                 : 32'h0;

   // ==========================================================
   // Row checks before a start
   logic [WORDS*32-1:0] tx_flat;
   always_comb
   begin
      for (int i = 0; i < WORDS; i++)
         tx_flat[i*32 +: 32] = tx_word[i];
   end
   wire [CHAIN_LEN-1:0] row = tx_flat[CHAIN_LEN-1:0];
   wire sampling = ~row[POS_HOLD];
   wire bad_ref = sampling && row[POS_DAC_LO +: DAC_W] != DAC_MID;
   wire chan_on = row[POS_MUX_LO + ANALOG_PIN];
   wire pin_drv = row[porta_pos(ANALOG_PIN, OFS_DRIVE)] | row[porta_pos(ANALOG_PIN, OFS_PULLUP)];
   wire bad_pin = chan_on & pin_drv;
   wire start_req = wr & is_ctrl & pwdata[CTRL_START];
   wire start_ok = start_req & ~busy & ~bad_ref & ~bad_pin;
   wire start_bad = start_req & ~busy & (bad_ref | bad_pin);

   // ==========================================================
   // Registers
   wire [WORDS*32-1:0] idle_flat = {{(WORDS*32-CHAIN_LEN){1'b0}}, chain_idle()};
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < WORDS; i++)
            tx_word[i] <= idle_flat[i*32 +: 32];
         extest_mode <= 1'b0;
         refused <= 1'b0;
      end
      else
      begin
         if (wr & is_tx & ~busy)
            tx_word[tx_idx] <= pwdata;
         if (wr & is_ctrl & ~busy)
            extest_mode <= pwdata[CTRL_EXTEST];
         if (start_bad)
            refused <= 1'b1;
         else if (start_ok)
            refused <= 1'b0;
      end
   end

   // ==========================================================
   // Link sequencer: capture, 205 shifts, update
   logic [DIV_W-1:0] div;
   logic [CHAIN_LEN-1:0] tx_sr, rx_sr;
   logic [CNT_W-1:0] bit_cnt;
   logic [1:0] tdo_s;
   logic en_prev;
   wire tick = div == DIV_LAST;
   always_ff @(posedge clk_sys)
      tdo_s <= {tdo_s[0], link.tdo};

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state <= BSC_IDLE;
         div <= '0;
         link.tck <= 1'b0;
         link.tdi <= 1'b0;
         link.capture <= 1'b0;
         link.shift <= 1'b0;
         link.update <= 1'b0;
         tx_sr <= '0;
         rx_sr <= '0;
         bit_cnt <= '0;
      end
      else
      begin
         div <= (state == BSC_IDLE || tick) ? '0 : div + 1'b1;
         case (state)
            BSC_IDLE:
            begin
               if (start_ok)
               begin
                  tx_sr <= row;
                  link.capture <= 1'b1;
                  state <= BSC_CAPTURE;
               end
            end
            default:
            begin
               if (tick && !link.tck)
               begin
                  link.tck <= 1'b1;
                  if (state == BSC_SHIFT)
                     rx_sr <= {tdo_s[1], rx_sr[CHAIN_LEN-1:1]};
               end
               else if (tick)
               begin
                  link.tck <= 1'b0;
                  if (state == BSC_CAPTURE)
                  begin
                     link.capture <= 1'b0;
                     link.shift <= 1'b1;
                     link.tdi <= tx_sr[0];
                     tx_sr <= tx_sr >> 1;
                     bit_cnt <= '0;
                     state <= BSC_SHIFT;
                  end
                  else if (state == BSC_SHIFT && bit_cnt == LAST_BIT)
                  begin
                     link.shift <= 1'b0;
                     link.update <= 1'b1;
                     state <= BSC_UPDATE;
                  end
                  else if (state == BSC_SHIFT)
                  begin
                     link.tdi <= tx_sr[0];
                     tx_sr <= tx_sr >> 1;
                     bit_cnt <= bit_cnt + 1'b1;
                  end
                  else
                  begin
                     link.update <= 1'b0;
                     state <= BSC_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign link.extest = extest_mode;

   // ==========================================================
   // Captured row and converter settling guard
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < WORDS; i++)
            rx_word[i] <= '0;
         settle_cnt <= '0;
         en_prev <= 1'b0;
      end
      else if (state == BSC_UPDATE && tick && link.tck)
      begin
         for (int i = 0; i < WORDS; i++)
            rx_word[i] <= 32'({{(WORDS*32-CHAIN_LEN){1'b0}}, rx_sr} >> (i*32));
         en_prev <= row[POS_CONVERTER_ENABLE_CELL] & extest_mode;
         if (row[POS_CONVERTER_ENABLE_CELL] & extest_mode & ~en_prev)
            settle_cnt <= SETTLE_W'(SETTLE_CYC);
      end
      else if (settle_cnt != '0)
         settle_cnt <= settle_cnt - 1'b1;
   end

endmodule

/* sim/bsc_chk.sv */
`timescale 1ns/1ps
module bsc_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Link
   input wire logic tck,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic extest
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // Test clock rises counted while shifting
   logic tck_q;
   logic [7:0] n_rise;
   always_ff @(posedge clk_sys)
   begin
      tck_q <= tck;
      if (sys_rst || !shift)
         n_rise <= 8'h00;
      else if (tck && !tck_q)
         n_rise <= n_rise + 8'h01;
   end

   // ==========================================================
   // Link framing
   chk_tck_high_len: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
      else $error("test clock high phase has wrong length");
   chk_tck_idle_low: assert property (!(capture || shift || update) |-> !tck)
      else $error("test clock runs outside a frame");
   chk_tdi_held: assert property (tck && $past(tck) |-> $stable(tdi) && $stable(shift))
      else $error("serial data changed while test clock high");
   chk_capture_then_shift: assert property ($rose(shift) |-> $fell(capture))
      else $error("shift did not follow capture");
   chk_shift_then_update: assert property ($fell(shift) |-> $rose(update))
      else $error("update did not follow shift");
   chk_phase_exclusive: assert property (!(shift && (update || capture)))
      else $error("frame phases overlap");
   chk_update_one_period: assert property ($rose(update) |-> update [*8] ##9 !update)
      else $error("update period has wrong length");
   chk_shift_len_bits: assert property ($fell(shift) |-> n_rise == 8'hcd)
      else $error("shift did not last the full chain length");
   chk_tdo_in_frame: assert property ($changed(tdo) |-> capture || shift)
      else $error("serial output moved outside capture or shift");
   chk_extest_steady: assert property ((shift || update) |-> $stable(extest))
      else $error("instruction changed within a frame");
endmodule

/* sim/bsc_tb.sv */
`timescale 1ns/1ps
module bsc_tb;
   import bsc_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, e, comp_in;
   logic prog_enable_in = 1'b0;
   logic [DAC_W-1:0] dac_code;
   logic [DAC_W-1:0] vin = 10'h130;
   logic [MUX_W-1:0] input_channel_mask;
   logic sample_hold, comparator_precharge_n, converter_enable, converter_busy;
   logic [PORT_CELLS-1:0] pin_cells;
   logic [31:0] seed = 32'h00012bea;
   logic [WORDS*32-1:0] row, exp_row, rx;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int busy_cyc = 0;

   bsc_link_if link();
   bsc_device u_bsc_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
      .comp_in(comp_in), .prog_enable_in(prog_enable_in), .dac_code(dac_code),
      .input_channel_mask(input_channel_mask), .sample_hold(sample_hold),
      .comparator_precharge_n(comparator_precharge_n), .converter_enable(converter_enable),
      .converter_busy(converter_busy), .pin_cells(pin_cells));
   bsc_tester u_bsc_tester (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   bsc_chk u_bsc_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(link.tck), .tdi(link.tdi),
      .tdo(link.tdo), .capture(link.capture), .shift(link.shift), .update(link.update),
      .extest(link.extest));

   // Comparator goes high once the reference code lies above the input level.
   assign comp_in = (dac_code > vin) === 1'b1;

   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (converter_busy === 1'b1)
         busy_cyc++;
      if (cyc == 90000)
      begin
         n_fail++;
         summarize();
      end
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Row of the window check; step 0 gives the quiet row.
   function automatic logic [WORDS*32-1:0] row_of(input int s);
      logic [WORDS*32-1:0] v;
      v = '0;
      v[POS_HOLD] = !(s == 2 || s == 7);
      v[POS_COMPARATOR_PRECHARGE_N] = !(s == 5 || s == 10);
      v[POS_PASSEN] = 1'b1;
      v[POS_MUX_LO +: MUX_W] = (s == 0) ? 8'h01 : 8'h08;
      v[POS_CONVERTER_ENABLE_CELL] = (s != 0);
      v[POS_DAC_LO +: DAC_W] = (s == 4 || s == 5) ? 10'h123 :
         (s == 9 || s == 10) ? 10'h143 : (s == 0) ? 10'h000 : 10'h200;
      return v;
   endfunction

   task automatic summarize();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic [WORDS*32-1:0] got, input logic [WORDS*32-1:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic start(input logic [WORDS*32-1:0] v, input logic ext);
      for (int i = 0; i < WORDS; i++)
         apb(1'b1, REG_TX0 + 8'(4 * i), v[32*i +: 32]);
      apb(1'b1, REG_CTRL, {30'h0, ext, 1'b1});
   endtask

   task automatic frame(input logic [WORDS*32-1:0] v, input logic ext);
      start(v, ext);
      r = 32'h1;
      while (r[STAT_BUSY] !== 1'b0)
         apb(1'b0, REG_STATUS, 32'h0);
      cmp(r, 0);
      for (int i = 0; i < WORDS; i++)
      begin
         apb(1'b0, REG_RX0 + 8'(4 * i), 32'h0);
         rx[32*i +: 32] = r;
      end
   endtask

   initial
   begin
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      apb(1'b0, 8'hfc, 32'h0);
      cmp(e, 1);
      cmp({dac_code, input_channel_mask, sample_hold, comparator_precharge_n},
         {10'h000, MUX_IDLE, 2'h3});
      $display("test reset done");
      for (int i = 0; i < WORDS; i++)
         row[32*i +: 32] = rnd();
      row[POS_HOLD] = 1'b1;
      row[POS_MUX_LO + 3] = 1'b0;
      row[POS_PEN] = 1'b0;
      prog_enable_in <= 1'b1;
      frame(row, 1'b0);
      frame(row, 1'b0);
      exp_row = row;
      exp_row[POS_PEN] = 1'b1;
      exp_row[POS_COMP] = 1'b0;
      cmp(rx[CHAIN_LEN-1:0], exp_row[CHAIN_LEN-1:0]);
      cmp({pin_cells, converter_enable}, 0);
      $display("test preload done");
      row[POS_CONVERTER_ENABLE_CELL] = 1'b1;
      busy_cyc = 0;
      frame(row, 1'b1);
      cmp({dac_code, input_channel_mask, sample_hold, comparator_precharge_n, converter_enable,
         pin_cells}, {row[POS_DAC_LO +: DAC_W], row[POS_MUX_LO +: MUX_W], row[POS_HOLD],
         row[POS_COMPARATOR_PRECHARGE_N], row[POS_CONVERTER_ENABLE_CELL], row[PORT_CELLS-1:0]});
      cmp(busy_cyc, DUMMY_CYC);
      $display("test extest done");
      exp_row = row_of(4);
      exp_row[POS_HOLD] = 1'b0;
      start(exp_row, 1'b1);
      apb(1'b0, REG_STATUS, 32'h0);
      cmp(r, 32'h2);
      $display("test reference refusal done");
      vin <= 10'h124 + 10'(rnd() % 31);
      for (int s = 1; s <= 11; s++)
      begin
         frame(row_of(s), s > 1);
         if (s == 2)
            cmp({sample_hold, dac_code}, {1'b0, DAC_MID});
         if (s == 5)
            cmp(comparator_precharge_n, 0);
         if (s == 6)
            cmp(rx[POS_COMP], 0);
         if (s == 11)
            cmp(rx[POS_COMP], 1);
      end
      $display("test window done");
      exp_row = row_of(1);
      exp_row[PORTA_DATA0 + CELLS_PER_PIN * ANALOG_PIN - OFS_DRIVE] = 1'b1;
      start(exp_row, 1'b1);
      apb(1'b0, REG_STATUS, 32'h0);
      cmp(r, 32'h2);
      $display("test pin refusal done");
      summarize();
   end
endmodule
